// *** hw/tws_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Two-wire link between master and slave; data is open drain
interface tws_if;
	logic scl; // Serial clock, always driven by the master
	logic sda_h_o; // Master data output, always low
	logic sda_h_oe; // Master pulls data low
	logic sda_d_o; // Slave data output, always low
	logic sda_d_oe; // Slave pulls data low
	logic sda; // Resolved wire level with pull-up

	// Wired-AND of both open-drain drivers
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
	modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
endinterface : tws_if
`default_nettype wire

// *** hw/tws_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// Write data buffer, single clock
module tws_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [WIDTH-1:0] s_data,
	// Drain side
	output logic m_valid,
	input wire logic m_ready,
	output logic [WIDTH-1:0] m_data
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q, rp_q;
	logic [PW:0] cnt_q;
	logic push, pop;

	assign s_ready = cnt_q != (PW+1)'(DEPTH);
	assign m_valid = cnt_q != '0;
	assign m_data = mem_q[rp_q];
	assign push = s_valid & s_ready;
	assign pop = m_valid & m_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= s_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
			end
			if (pop) begin
				rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : tws_fifo

// Bus master: start, address byte, data bytes, stop
module tws_master
	import tws_pkg::*;
#(
	parameter int unsigned QTR_CYCLES = SCL_QTR_CYC // Quarter clock period in cycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial link
	tws_if.host bus,
	// Command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_rw,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	// Write data stream
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [DATA_W-1:0] wr_data,
	// Read data and status
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic done,
	output logic nack
);
	localparam int unsigned DW = $clog2(QTR_CYCLES + 1);

	logic [DW-1:0] div_q; // Quarter-period divider
	logic tick;
	tws_ms_state_type state_q;
	logic [1:0] ph_q; // Quarter within a bit
	logic [3:0] slot_q; // Bit slot, 8 is acknowledge
	logic [DATA_W-1:0] sr_q;
	logic tx_q, first_q, rw_q, ack_q;
	logic [7:0] left_q; // Data bytes still to move
	logic scl_q, oe_q;
	logic sda_m_q, sda_s_q; // Data line synchroniser
	logic f_valid, f_pop;
	logic [DATA_W-1:0] f_data;

	// Stalls the bus with clock low while empty
	tws_fifo #(.WIDTH(DATA_W), .DEPTH(WR_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.s_valid(wr_valid),
		.s_ready(wr_ready),
		.s_data(wr_data),
		.m_valid(f_valid),
		.m_ready(f_pop),
		.m_data(f_data)
	);

	assign tick = div_q == '0;
	assign cmd_ready = state_q == MS_IDLE;
	assign f_pop = state_q == MS_FEED;

	// Divider for the serial clock phases
	always_ff @(posedge clk) begin
		if (!rst_b || tick) begin
			div_q <= DW'(QTR_CYCLES - 1);
		end else begin
			div_q <= div_q - DW'(1);
		end
	end

	// Data line synchroniser
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// Transfer sequencer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= MS_IDLE;
			ph_q <= 2'h0;
			slot_q <= 4'h0;
			sr_q <= 8'h00;
			tx_q <= 1'b1;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			left_q <= 8'h00;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			done <= 1'b0;
			nack <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			done <= 1'b0;
			unique case (state_q)
				MS_IDLE: begin
					if (cmd_valid) begin
						sr_q <= {cmd_addr, cmd_rw};
						rw_q <= cmd_rw;
						left_q <= cmd_len;
						nack <= 1'b0;
						state_q <= MS_START;
					end
				end
				MS_START: begin
					// Data falls with clock high, then clock falls
					if (tick) begin
						if (!oe_q) begin
							oe_q <= 1'b1;
						end else begin
							scl_q <= 1'b0;
							tx_q <= 1'b1;
							first_q <= 1'b1;
							slot_q <= 4'h0;
							ph_q <= 2'h0;
							state_q <= MS_BYTE;
						end
					end
				end
				MS_FEED: begin
					// Clock held low until a byte is buffered
					if (f_valid) begin
						sr_q <= f_data;
						left_q <= left_q - 8'h01;
						slot_q <= 4'h0;
						ph_q <= 2'h0;
						state_q <= MS_BYTE;
					end
				end
				MS_BYTE: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: begin
								// Data changes while clock low
								if (slot_q != 4'h8) begin
									oe_q <= tx_q & ~sr_q[DATA_W-1];
								end else begin
									// Ack every read byte but the last one
									oe_q <= ~tx_q & (left_q != 8'h01);
								end
							end
							2'h1: scl_q <= 1'b1;
							2'h2: begin
								if (slot_q != 4'h8) begin
									sr_q <= {sr_q[DATA_W-2:0], sda_s_q};
								end else begin
									ack_q <= sda_s_q;
								end
							end
							2'h3: begin
								scl_q <= 1'b0;
								slot_q <= slot_q + 4'h1;
								if (slot_q == 4'h8) begin
									slot_q <= 4'h0;
									first_q <= 1'b0;
									if (tx_q && ack_q) begin
										nack <= 1'b1;
										state_q <= MS_STOP;
									end else if (tx_q && first_q && rw_q) begin
										tx_q <= 1'b0;
									end else if (tx_q) begin
										state_q <= (left_q == 8'h00) ? MS_STOP : MS_FEED;
									end else begin
										rd_valid <= 1'b1;
										rd_data <= sr_q;
										left_q <= left_q - 8'h01;
										if (left_q == 8'h01) begin
											// Withheld ack, so a stop must follow
											state_q <= MS_STOP;
										end
									end
								end
							end
							default: ;
						endcase
					end
				end
				MS_STOP: begin
					// Data rises with clock high
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: oe_q <= 1'b1;
							2'h1: scl_q <= 1'b1;
							2'h2: oe_q <= 1'b0;
							2'h3: begin
								done <= 1'b1;
								state_q <= MS_IDLE;
							end
							default: ;
						endcase
					end
				end
				default: state_q <= MS_IDLE;
			endcase
		end
	end

	assign bus.scl = scl_q;
	assign bus.sda_h_o = 1'b0;
	assign bus.sda_h_oe = oe_q;

endmodule : tws_master
`default_nettype wire

// *** hw/tws_master_unused.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** hw/tws_pkg.sv ***
// Shared constants for the two-wire serial memory slave and its bus master
package tws_pkg;

	// Memory geometry
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned MEM_DEPTH = 128;
	localparam int unsigned PAGE_LOW_W = 2;
	localparam int unsigned PAGE_HIGH_W = 5;
	localparam int unsigned PAGE_BYTES = 4;
	localparam int unsigned BITS_PER_BYTE = 8;

	// Clock rate of both ends
	localparam int unsigned CLK_PERIOD_NS = 50;

	// Longest self-timed programming time, rounded down to cycles
	localparam int unsigned PROG_MAX_NS = 10_000_000;
	localparam int unsigned PROG_CYC = PROG_MAX_NS / CLK_PERIOD_NS;

	// Master serial clock quarter period (100 kHz), least time, rounded up
	localparam int unsigned SCL_QTR_NS = 2500;
	localparam int unsigned SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Write data buffer in the master
	localparam int unsigned WR_FIFO_DEPTH = 8;

	// Slave bus states
	typedef enum logic [3:0] {
		SL_IDLE = 4'h0,
		SL_ADDR = 4'h1,
		SL_ADDR_ACK = 4'h2,
		SL_WDATA = 4'h3,
		SL_WDATA_ACK = 4'h4,
		SL_RDATA = 4'h5,
		SL_RDATA_ACK = 4'h6,
		SL_RDATA_NEXT = 4'h7,
		SL_IGNORE = 4'h8,
		SL_PROG = 4'h9
	} tws_sl_state_type;

	// Master sequencer states
	typedef enum logic [2:0] {
		MS_IDLE = 3'h0,
		MS_START = 3'h1,
		MS_BYTE = 3'h2,
		MS_FEED = 3'h3,
		MS_STOP = 3'h4
	} tws_ms_state_type;

endpackage : tws_pkg

// *** hw/tws_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
module tws_slave
	import tws_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYC // Programming time in cycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial link
	tws_if.dev bus,
	// Status
	output logic prog_busy,
	output logic standby
);

	localparam int unsigned TMR_W = $clog2(PROG_CYCLES + 1);
	localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(PROG_CYCLES - 1);
	localparam logic [3:0] CNT_FULL = 4'(BITS_PER_BYTE);
	localparam logic [3:0] CNT_LAST = 4'(BITS_PER_BYTE - 1);

	// Synchroniser stages and previous sample
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	// Bus sequencing
	tws_sl_state_type state_q;
	logic [3:0] cnt_q; // Bits moved in current byte
	logic [DATA_W-1:0] sr_q; // Shift register
	logic oe_q; // Pull data low
	// Address and direction
	logic [ADDR_W-1:0] addr_q;
	logic rw_q;
	// Page buffer
	logic [PAGE_HIGH_W-1:0] page_q;
	logic [PAGE_LOW_W-1:0] wptr_q;
	logic [DATA_W-1:0] pbuf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_q; // Bytes waiting for programming
	// Programming timer
	logic [TMR_W-1:0] tmr_q;
	// Nonvolatile array, not cleared by reset
	logic [DATA_W-1:0] mem_q [MEM_DEPTH];

	// Decoded events
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic byte_in, addr_take, data_take, rd_ack_seen, prog_go, prog_done;

	// Two flip-flops on each pin before use
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= bus.scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Edges and line conditions
	always_comb begin
		scl_rise = scl_s_q & ~scl_p_q;
		scl_fall = ~scl_s_q & scl_p_q;
		// Data moving while clock high is only start or stop
		start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
		stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
		byte_in = (state_q == SL_ADDR || state_q == SL_WDATA) && scl_fall && cnt_q == CNT_FULL;
		addr_take = byte_in && state_q == SL_ADDR;
		data_take = byte_in && state_q == SL_WDATA;
		rd_ack_seen = state_q == SL_RDATA_ACK && scl_rise && !sda_s_q;
		// Only a stop after at least one whole acked byte programs
		prog_go = stop_ev && (state_q == SL_WDATA || state_q == SL_WDATA_ACK) && |mask_q;
		prog_done = state_q == SL_PROG && tmr_q == '0;
	end

	// Bus state machine and shifter
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			// Idle with data released after reset
			state_q <= SL_IDLE;
			cnt_q <= 4'h0;
			sr_q <= 8'h00;
			oe_q <= 1'b0;
		end else if (state_q == SL_PROG) begin
			// Deaf to the bus, so polling goes unanswered
			oe_q <= 1'b0;
			if (prog_done) begin
				state_q <= SL_IDLE;
			end
		end else if (stop_ev) begin
			// Stop always ends the transaction
			state_q <= prog_go ? SL_PROG : SL_IDLE;
			oe_q <= 1'b0;
		end else if (start_ev) begin
			// Start from any state but SL_PROG restarts address phase
			state_q <= SL_ADDR;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				SL_IDLE, SL_IGNORE: begin
					// Waiting for start or stop
					oe_q <= 1'b0;
				end
				SL_ADDR, SL_WDATA: begin
					// Sample on rising clock
					if (scl_rise && cnt_q != CNT_FULL) begin
						sr_q <= {sr_q[DATA_W-2:0], sda_s_q};
						cnt_q <= cnt_q + 4'h1;
					end
					// Acknowledge once clock falls after eighth bit
					if (byte_in) begin
						oe_q <= 1'b1;
						state_q <= (state_q == SL_ADDR) ? SL_ADDR_ACK : SL_WDATA_ACK;
					end
				end
				SL_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							// Direction one: first read byte, first bit out
							sr_q <= mem_q[addr_q];
							oe_q <= ~mem_q[addr_q][DATA_W-1];
							state_q <= SL_RDATA;
						end else begin
							oe_q <= 1'b0;
							state_q <= SL_WDATA;
						end
					end
				end
				SL_WDATA_ACK: begin
					// Release after ninth clock
					if (scl_fall) begin
						oe_q <= 1'b0;
						cnt_q <= 4'h0;
						state_q <= SL_WDATA;
					end
				end
				SL_RDATA: begin
					// Shift next bit on falling clock
					if (scl_fall) begin
						if (cnt_q == CNT_LAST) begin
							oe_q <= 1'b0;
							state_q <= SL_RDATA_ACK;
						end else begin
							sr_q <= {sr_q[DATA_W-2:0], 1'b0};
							oe_q <= ~sr_q[DATA_W-2];
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				SL_RDATA_ACK: begin
					// Master acknowledge decides whether to go on
					if (scl_rise) begin
						state_q <= sda_s_q ? SL_IGNORE : SL_RDATA_NEXT;
					end
				end
				SL_RDATA_NEXT: begin
					// Address already advanced; load next byte
					if (scl_fall) begin
						sr_q <= mem_q[addr_q];
						oe_q <= ~mem_q[addr_q][DATA_W-1];
						cnt_q <= 4'h0;
						state_q <= SL_RDATA;
					end
				end
				default: begin
					// Unused codes recover to idle
					state_q <= SL_IDLE;
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Word address and direction
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addr_q <= 7'h00;
			rw_q <= 1'b0;
		end else if (addr_take) begin
			addr_q <= sr_q[DATA_W-1:1];
			rw_q <= sr_q[0];
		end else if (rd_ack_seen) begin
			// Whole address counts, 127 wraps to 0 by width
			addr_q <= addr_q + 7'h01;
		end
	end

	// Page buffer for byte and page writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			page_q <= 5'h00;
			wptr_q <= 2'h0;
			mask_q <= 4'h0;
		end else if (addr_take) begin
			page_q <= sr_q[DATA_W-1:PAGE_LOW_W+1];
			wptr_q <= sr_q[PAGE_LOW_W:1];
			mask_q <= 4'h0;
		end else if (data_take) begin
			// Low bits roll within the page, later bytes overwrite
			pbuf_q[wptr_q] <= sr_q;
			mask_q[wptr_q] <= 1'b1;
			wptr_q <= wptr_q + 2'h1;
		end else if (prog_done) begin
			mask_q <= 4'h0;
		end
	end

	// Self-timed programming interval
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tmr_q <= '0;
		end else if (prog_go) begin
			tmr_q <= TMR_LOAD;
		end else if (state_q == SL_PROG && tmr_q != '0) begin
			tmr_q <= tmr_q - TMR_W'(1);
		end
	end

	// Array update when the interval ends; keeps its contents over reset
	always_ff @(posedge clk) begin
		if (rst_b && prog_done) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (mask_q[i]) begin
					mem_q[{page_q, PAGE_LOW_W'(i)}] <= pbuf_q[i];
				end
			end
		end
	end

	// Open-drain drive and status
	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe = oe_q;
	assign prog_busy = state_q == SL_PROG;
	assign standby = state_q == SL_IDLE;

endmodule : tws_slave
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tws_pkg::*;
	localparam int unsigned PROG = 2000; // Long enough to refuse one poll
	logic clk, rst_b; // Clock and reset
	logic cmd_valid, cmd_ready, cmd_rw, wr_valid, wr_ready, rd_valid, done, nack, prog_busy, standby;
	logic [6:0] cmd_addr, addr_r; // Word addresses
	logic [7:0] cmd_len, wr_data, rd_data, sh_q, exp_first; // Bytes
	int error_cnt, samples_checked, wire_bits; // Counters
	logic [7:0] mem_exp [MEM_DEPTH]; // Expected array
	bit known [MEM_DEPTH]; // Written locations
	logic nack_seen; // Last nack at done
	int len_r; // Random write length
	logic [7:0] rd_q [$]; // Bytes read

	tws_if tws_if_inst ();
	tws_master #(.QTR_CYCLES(10)) tws_master_inst (.clk(clk), .rst_b(rst_b), .bus(tws_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
	tws_slave #(.PROG_CYCLES(PROG)) tws_slave_inst (.clk(clk), .rst_b(rst_b), .bus(tws_if_inst),
		.prog_busy(prog_busy), .standby(standby));
	tws_link_assertions #(.PROG_CYCLES(PROG)) tws_link_assertions_inst (.clk(clk), .rst_b(rst_b),
		.scl(tws_if_inst.scl), .sda_h_o(tws_if_inst.sda_h_o), .sda_h_oe(tws_if_inst.sda_h_oe),
		.sda_d_o(tws_if_inst.sda_d_o), .sda_d_oe(tws_if_inst.sda_d_oe), .sda(tws_if_inst.sda),
		.prog_busy(prog_busy), .standby(standby));

	always #25 clk = ~clk;

	// A start rearms the first-byte capture
	always @(negedge tws_if_inst.sda) begin
		if (tws_if_inst.scl) begin
			wire_bits = 0;
		end
	end

	// First byte off the wire must match the command
	always @(posedge tws_if_inst.scl) begin
		if (wire_bits < 8) begin
			sh_q = {sh_q[6:0], tws_if_inst.sda};
			wire_bits++;
			if (wire_bits == 8) chk(sh_q, exp_first);
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// Bounded wait ran out
	task automatic expire();
		chk(8'h00, 8'h01);
		conclude();
	endtask : expire

	// Page-local address: only the low two bits advance
	function automatic logic [6:0] pg(input logic [6:0] a, input int i);
		return {a[6:2], a[1:0] + 2'(i)};
	endfunction : pg

	// One byte into the write buffer; valid stays up for chaining
	task automatic push(input logic [7:0] d);
		int k;
		k = 0;
		wr_valid <= 1'b1;
		wr_data <= d;
		@(negedge clk);
		while (wr_ready !== 1'b1) begin
			k++;
			if (k > 30000) expire();
			@(negedge clk);
		end
		@(posedge clk);
	endtask : push

	task automatic cmd(input logic rw, input logic [6:0] a, input logic [7:0] n);
		int k;
		k = 0;
		exp_first = {a, rw};
		cmd_valid <= 1'b1;
		cmd_rw <= rw;
		cmd_addr <= a;
		cmd_len <= n;
		@(negedge clk);
		while (cmd_ready !== 1'b1) begin
			k++;
			if (k > 100) expire();
			@(negedge clk);
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask : cmd

	// Wait for done, gathering read bytes on the way
	task automatic finish_cmd();
		int k;
		k = 0;
		rd_q = {};
		@(negedge clk);
		while (done !== 1'b1) begin
			if (rd_valid === 1'b1) rd_q.push_back(rd_data);
			k++;
			if (k > 40000) expire();
			@(negedge clk);
		end
		nack_seen = nack;
		@(posedge clk);
	endtask : finish_cmd

	task automatic wr_txn(input logic [6:0] a, input int n, input bit pre);
		logic [7:0] d [$];
		int k;
		for (int i = 0; i < n; i++) begin
			d.push_back(8'($urandom));
			mem_exp[pg(a, i)] = d[i];
			known[pg(a, i)] = 1'b1;
		end
		// Prefilled case fills the buffer before the command
		if (pre) begin
			foreach (d[i]) push(d[i]);
			wr_valid <= 1'b0;
			@(negedge clk);
			chk(wr_ready, n < int'(WR_FIFO_DEPTH));
			@(posedge clk);
		end
		cmd(1'b0, a, 8'(n));
		// Otherwise feed after the command with gaps of 1 to 40 cycles, well ahead of the link
		if (!pre) begin
			foreach (d[i]) begin
				push(d[i]);
				wr_valid <= 1'b0;
				repeat (1 + $urandom % 40) @(posedge clk);
			end
		end
		finish_cmd();
		chk(nack_seen, 1'b0);
		@(negedge clk);
		chk(prog_busy, 1'b1);
		@(posedge clk);
		cmd(1'b0, a, 8'h00);
		finish_cmd();
		chk(nack_seen, 1'b1);
		k = 0;
		while (nack_seen !== 1'b0) begin
			k++;
			if (k > 20) expire();
			cmd(1'b0, a, 8'h00);
			finish_cmd();
		end
		@(negedge clk);
		chk({prog_busy, standby}, 8'h01);
		@(posedge clk);
	endtask : wr_txn

	task automatic rd_txn(input logic [6:0] a, input int n);
		logic [6:0] p;
		cmd(1'b1, a, 8'(n));
		finish_cmd();
		chk(8'(rd_q.size()), 8'(n));
		foreach (rd_q[i]) begin
			p = a + 7'(i);
			if (known[p]) chk(rd_q[i], mem_exp[p]);
		end
	endtask : rd_txn

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_rw = 1'b0;
		cmd_addr = 7'h00;
		cmd_len = 8'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		error_cnt = 0;
		samples_checked = 0;
		wire_bits = 9;
		void'($urandom(32'h7a09));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk({prog_busy, standby, tws_if_inst.sda}, 8'h03);
		@(posedge clk);
		// Eight bytes into one page wrap twice
		wr_txn(7'h7d, 8, 1'b1);
		wr_txn(7'h00, 2, 1'b0);
		// Reset in mid-run; array contents must survive it
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk({prog_busy, standby, tws_if_inst.sda}, 8'h03);
		@(posedge clk);
		// Read runs over the top of the array
		rd_txn(7'h7c, 6);
		rd_txn(7'h01, 1);
		for (int t = 0; t < 5; t++) begin
			// Stay inside the page so no unwritten cell is read back
			addr_r = 7'($urandom);
			len_r = 1 + $urandom % (4 - addr_r[1:0]);
			wr_txn(addr_r, len_r, 1'b0);
			rd_txn(addr_r, len_r);
		end
		conclude();
	end
endmodule : tb
`default_nettype wire

// *** verification/tws_link_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the link wires and slave status
module tws_link_assertions #(
	parameter int unsigned PROG_CYCLES = 200 // Programming time in cycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link wires
	input wire logic scl,
	input wire logic sda_h_o,
	input wire logic sda_h_oe,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	input wire logic sda,
	// Slave status
	input wire logic prog_busy,
	input wire logic standby
);
	int unsigned busy_cnt_q; // Busy cycles so far

	// Count programming time; a counter avoids a huge repetition
	always_ff @(posedge clk) begin
		if (!rst_b || !prog_busy) begin
			busy_cnt_q <= '0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_slave_low_clock: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
		else $error("slave data moved while clock high");
	chk_idle_released: assert property (standby |-> !sda_d_oe)
		else $error("slave drives data while idle");
	chk_busy_silent: assert property (prog_busy |-> !sda_d_oe)
		else $error("slave answers while programming");
	chk_busy_length: assert property (prog_busy |-> busy_cnt_q < PROG_CYCLES)
		else $error("programming runs too long");
	chk_busy_after_stop: assert property ($rose(prog_busy) |-> scl && sda && !$past(sda, 6))
		else $error("programming began without a stop");
	chk_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> !$past(sda_d_oe))
		else $error("stop while slave still drove data");
	chk_stop_standby: assert property (scl && $past(scl) && $rose(sda) |-> ##[1:8] (standby || prog_busy))
		else $error("stop did not end the transaction");
	chk_start_wakes: assert property (scl && $past(scl) && $fell(sda) && !prog_busy |-> ##[1:8] !standby)
		else $error("start not taken");
	chk_one_driver: assert property (scl && sda_d_oe |-> !sda_h_oe)
		else $error("both ends drive data in one bit");
	chk_open_drain: assert property (sda_d_oe || sda_h_oe |-> !sda && !sda_d_o && !sda_h_o)
		else $error("driven data line not low");

	// Main scenarios reached
	cover property ($rose(prog_busy));
	cover property ($fell(standby));
	cover property (scl && sda_d_oe && !sda);
endmodule : tws_link_assertions
`default_nettype wire
